//--- bench/tucc_timer_checker.sv
// port-level assertions for the timer count/clear slice
`timescale 1ns/1ps
`default_nettype none
module tucc_timer_checker
    import tucc_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // events
    input wire logic        capture_a,
    input wire logic        capture_b,
    input wire logic        sync_clear_in,
    input wire logic        match_a,
    input wire logic        match_b,
    input wire logic        sync_clear_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("pready missing after setup");
    property p_no_ready_idle;
        !psel |=> !pready;
    endproperty
    a_no_ready_idle: assert property (p_no_ready_idle)
        else $error("pready without a request");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    property p_err_with_ready;
        pslverr |-> pready && $past(psel);
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("pslverr outside a response");
    property p_rdata_hold;
        !(psel && !penable) |=> $stable(prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("prdata moved without a setup");
    property p_capture_a;
        capture_a && !(psel && penable && pwrite) |-> ##1 match_a;
    endproperty
    a_capture_a: assert property (p_capture_a)
        else $error("capture a gave no event a");
    property p_capture_b;
        capture_b && !(psel && penable && pwrite) |-> ##1 match_b;
    endproperty
    a_capture_b: assert property (p_capture_b)
        else $error("capture b gave no event b");
    property p_sync_cause;
        sync_clear_out |-> match_a || match_b || $past(sync_clear_in);
    endproperty
    a_sync_cause: assert property (p_sync_cause)
        else $error("sync clear out without a clear");
endmodule

bind tucc_timer tucc_timer_checker u_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .capture_a, .capture_b, .sync_clear_in, .match_a, .match_b, .sync_clear_out
);
`default_nettype wire

//--- bench/tucc_timer_test.sv
// self-checking testbench of the timer count/clear slice
`timescale 1ns/1ps
`default_nettype none
module tucc_timer_test;
    import tucc_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [3:0]        src = 4'h0;
    logic [2:0]        ev = 3'h0;
    logic              phase_up = 1'b0;
    logic              phase_down = 1'b0;
    logic              match_a;
    logic              match_b;
    logic              sync_clear_out;
    logic [31:0]       rd;
    logic              err;
    int                error_cnt = 0;
    int                n_compared = 0;

    tucc_timer dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_clock_pin_a(src[0]), .ext_clock_pin_c(src[1]),
        .internal_clock_src(src[2]), .ch5_overflow(src[3]), .phase_up, .phase_down,
        .capture_a(ev[0]), .capture_b(ev[1]), .sync_clear_in(ev[2]),
        .match_a, .match_b, .sync_clear_out
    );

    initial
        forever #4 pclk = ~pclk;

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until the edge that sees pready; data taken at that edge
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] v);
        apb(1'b1, idx, v);
    endtask

    task automatic chk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        cmp(rd, exp);
    endtask

    task automatic tog(input int b, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            src[b] <= ~src[b];
            @(posedge pclk);
        end
    endtask

    // event outputs are registered, so they are looked at one edge later
    task automatic pulse(input int b, output logic [2:0] seen);
        @(posedge pclk);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev[b] <= 1'b0;
        @(posedge pclk);
        seen = {sync_clear_out, match_b, match_a};
    endtask

    task automatic t_regs();
        chk(IDX_CONTROL, 32'h0);
        wr(IDX_CONTROL, 32'hFFFFFFFF);
        chk(IDX_CONTROL, 32'h7F);
        wr(IDX_CONTROL, 32'h4);
        wr(IDX_COUNT, 32'h1234BEEF);
        chk(IDX_COUNT, 32'hBEEF);
        for (int i = 0; i < 4; i++)
        begin
            chk(IDX_GEN_A + 16'(2 * i), 32'hFFFF);
            wr(IDX_GEN_A + 16'(2 * i), 32'hFFFF1230 + 32'(i));
            chk(IDX_GEN_A + 16'(2 * i), 32'h1230 + 32'(i));
        end
        apb(1'b0, 16'h0000, 32'h0);
        cmp({rd[30:0], err}, 32'h1);
    endtask

    // the prescaler runs free, so one extra tick is allowed
    task automatic t_psc();
        logic [31:0] e;
        for (int p = 0; p < 4; p++)
        begin
            wr(IDX_CONTROL, 32'(p));
            wr(IDX_COUNT, 32'h0);
            repeat (128) @(posedge pclk);
            apb(1'b0, IDX_COUNT, 32'h0);
            e = 32'd128 >> (2 * p);
            n_compared++;
            if (rd !== e && rd !== e + 32'h1)
            begin
                error_cnt++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rd, e);
            end
        end
        for (int p = 4; p < 8; p++)
            for (int q = 0; q < 4; q++)
            begin
                wr(IDX_CONTROL, 32'(p));
                wr(IDX_COUNT, 32'h0);
                tog(q, 4);
                chk(IDX_COUNT, (p == q + 4) ? 32'h2 : 32'h0);
            end
    endtask

    task automatic t_edge();
        for (int e = 0; e < 4; e++)
        begin
            wr(IDX_CONTROL, 32'(e << 3) | 32'h4);
            wr(IDX_COUNT, 32'h0);
            tog(0, 4);
            chk(IDX_COUNT, (e < 2) ? 32'h2 : 32'h4);
        end
    endtask

    task automatic t_clear();
        logic [2:0] seen;
        wr(IDX_MODE, 32'h1);
        for (int c = 0; c < 4; c++)
            for (int v = 0; v < 3; v++)
            begin
                wr(IDX_CONTROL, 32'(c << 5) | 32'h4);
                wr(IDX_COUNT, 32'h5);
                pulse(v, seen);
                cmp({29'h0, seen}, {29'h0, c == v + 1, v == 1, v == 0});
                chk(IDX_COUNT, (c == v + 1) ? 32'h0 : 32'h5);
            end
        chk(IDX_GEN_A, 32'h5);
        wr(IDX_MODE, 32'h0);
        wr(IDX_COUNT, 32'h5);
        pulse(2, seen);
        cmp({29'h0, seen}, 32'h0);
        chk(IDX_COUNT, 32'h5);
        wr(IDX_GEN_A, 32'h2);
        wr(IDX_CONTROL, 32'h24);
        wr(IDX_COUNT, 32'h0);
        tog(0, 6);
        chk(IDX_COUNT, 32'h0);
    endtask

    task automatic t_phase();
        wr(IDX_MODE, 32'h2);
        wr(IDX_CONTROL, 32'h4);
        wr(IDX_COUNT, 32'hA);
        tog(0, 4);
        @(posedge pclk);
        phase_up <= 1'b1;
        repeat (3) @(posedge pclk);
        phase_up <= 1'b0;
        phase_down <= 1'b1;
        @(posedge pclk);
        phase_down <= 1'b0;
        chk(IDX_COUNT, 32'hC);
        wr(IDX_MODE, 32'h0);
    endtask

    task automatic end_sim();
        if (error_cnt == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_psc();
        t_edge();
        t_clear();
        t_phase();
        end_sim();
    end
endmodule
`default_nettype wire

//--- common/tucc_cnt_if.sv
// count clock selection signals between the slice and its clock selector
`timescale 1ns/1ps
`default_nettype none
interface tucc_cnt_if;
    import tucc_pkg::*;
    tucc_psc_t  psc;
    logic [1:0] edge_sel;
    logic       phase_mode;
    logic       ext_a;
    logic       ext_c;
    logic       internal_src;
    logic       ch5_ovf;
    logic       phase_up;
    logic       phase_down;
    logic       tick_up;
    logic       tick_down;

    modport ctrl (
        output psc, edge_sel, phase_mode, ext_a, ext_c, internal_src, ch5_ovf,
               phase_up, phase_down,
        input  tick_up, tick_down
    );
    modport sel (
        input  psc, edge_sel, phase_mode, ext_a, ext_c, internal_src, ch5_ovf,
               phase_up, phase_down,
        output tick_up, tick_down
    );
endinterface
`default_nettype wire

//--- common/tucc_pkg.sv
// constants, field layout and state types of the timer count/clear slice
package tucc_pkg;

    localparam int unsigned ADDR_W = 20;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_CONTROL = 16'hFE80;
    localparam logic [15:0] IDX_MODE    = 16'hFE81;
    localparam logic [15:0] IDX_COUNT   = 16'hFE86;
    localparam logic [15:0] IDX_GEN_A   = 16'hFE88;
    localparam logic [15:0] IDX_GEN_B   = 16'hFE8A;
    localparam logic [15:0] IDX_GEN_C   = 16'hFE8C;
    localparam logic [15:0] IDX_GEN_D   = 16'hFE8E;

    // reset values and register masks
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] GEN_RESET     = 16'hFFFF;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [1:0]  MODE_RESET    = 2'h0;
    localparam logic [7:0]  CONTROL_MASK  = 8'h7F;
    localparam logic [1:0]  MODE_MASK     = 2'h3;

    // control register fields
    localparam int unsigned PSC_LSB  = 0;
    localparam int unsigned EDGE_LSB = 3;
    localparam int unsigned CLR_LSB  = 5;

    // mode register bits
    localparam int unsigned MODE_SYNC_BIT  = 0;
    localparam int unsigned MODE_PHASE_BIT = 1;

    localparam int unsigned PRESC_W = 6;

    typedef enum logic [2:0] {
        PSC_DIV1,
        PSC_DIV4,
        PSC_DIV16,
        PSC_DIV64,
        PSC_EXT_A,
        PSC_EXT_C,
        PSC_INTERNAL,
        PSC_CH5_OVF
    } tucc_psc_t;

    typedef enum logic [1:0] {
        CLR_NONE,
        CLR_GEN_A,
        CLR_GEN_B,
        CLR_SYNC
    } tucc_clr_t;

    typedef struct packed {
        logic [PRESC_W-1:0] presc;
        logic               prev_level;
    } tucc_clk_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] gen_a;
        logic [15:0] gen_b;
        logic [15:0] gen_c;
        logic [15:0] gen_d;
        logic [7:0]  control;
        logic [1:0]  mode;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        match_a;
        logic        match_b;
        logic        sync_out;
    } tucc_state_t;

endpackage

//--- hdl/tucc_clk_sel.sv
// count clock source selection, prescaler and edge detection
`timescale 1ns/1ps
`default_nettype none
module tucc_clk_sel
    import tucc_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // selection and ticks
    tucc_cnt_if.sel   cif
);

    tucc_clk_state_t s;
    tucc_clk_state_t next_s;
    logic            level;
    logic            rise;
    logic            fall;

    always_comb
    begin
        next_s       = s;
        next_s.presc = s.presc + 1'b1;
        case (cif.psc)
            PSC_DIV4:     level = s.presc[1];
            PSC_DIV16:    level = s.presc[3];
            PSC_DIV64:    level = s.presc[5];
            PSC_EXT_A:    level = cif.ext_a;
            PSC_EXT_C:    level = cif.ext_c;
            PSC_INTERNAL: level = cif.internal_src;
            PSC_CH5_OVF:  level = cif.ch5_ovf;
            default:      level = 1'b0;
        endcase
        next_s.prev_level = level;
        rise = level & ~s.prev_level;
        fall = ~level & s.prev_level;
        // phase counting overrides both source and edge selection
        if (cif.phase_mode)
        begin
            cif.tick_up   = cif.phase_up & ~cif.phase_down;
            cif.tick_down = cif.phase_down & ~cif.phase_up;
        end
        else if (cif.psc == PSC_DIV1)
        begin
            cif.tick_up   = 1'b1;
            cif.tick_down = 1'b0;
        end
        else if (cif.edge_sel[1])
        begin
            cif.tick_up   = rise | fall;
            cif.tick_down = 1'b0;
        end
        else if (cif.edge_sel[0])
        begin
            cif.tick_up   = fall;
            cif.tick_down = 1'b0;
        end
        else
        begin
            cif.tick_up   = rise;
            cif.tick_down = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else
            s <= next_s;
    end

endmodule
`default_nettype wire

//--- hdl/tucc_timer.sv
// timer slice: counter, four general registers, count control, apb slave
//
// Functional notes
// - counter is read/write and counts up, or up and down in phase counting
// - rising edge selection counts on rising edges
// - falling or both edges per edge field, except PSC_DIV1, which counts every pclk cycle
// - phase counting ignores clock and edge selection
// - clear field zero never clears counter
// - clear on general A match or capture
// - clear on general B match or capture
// - synchronous clear follows other channels' clears
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tucc_timer
    import tucc_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // count clock sources
    input  wire logic              ext_clock_pin_a,
    input  wire logic              ext_clock_pin_c,
    input  wire logic              internal_clock_src,
    input  wire logic              ch5_overflow,
    input  wire logic              phase_up,
    input  wire logic              phase_down,
    // capture and synchronous clearing
    input  wire logic              capture_a,
    input  wire logic              capture_b,
    input  wire logic              sync_clear_in,
    // events
    output logic                   match_a,
    output logic                   match_b,
    output logic                   sync_clear_out
);

    tucc_state_t s;
    tucc_state_t next_s;
    tucc_cnt_if  cif ();

    logic        setup;
    logic        access;
    logic        event_a;
    logic        event_b;
    logic        clear_now;
    tucc_clr_t   clr_sel;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        addr_hit = (a == {2'b00, idx, 2'b00});
    endfunction

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        addr_known = addr_hit(a, IDX_CONTROL) || addr_hit(a, IDX_MODE)
                  || addr_hit(a, IDX_COUNT) || addr_hit(a, IDX_GEN_A)
                  || addr_hit(a, IDX_GEN_B) || addr_hit(a, IDX_GEN_C)
                  || addr_hit(a, IDX_GEN_D);
    endfunction

    assign cif.psc          = tucc_psc_t'(s.control[PSC_LSB +: 3]);
    assign cif.edge_sel     = s.control[EDGE_LSB +: 2];
    assign cif.phase_mode   = s.mode[MODE_PHASE_BIT];
    assign cif.ext_a        = ext_clock_pin_a;
    assign cif.ext_c        = ext_clock_pin_c;
    assign cif.internal_src = internal_clock_src;
    assign cif.ch5_ovf      = ch5_overflow;
    assign cif.phase_up     = phase_up;
    assign cif.phase_down   = phase_down;

    tucc_clk_sel u_clk_sel (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif.sel)
    );

    always_comb
    begin
        next_s          = s;
        next_s.ready    = 1'b0;
        next_s.slverr   = 1'b0;
        next_s.match_a  = 1'b0;
        next_s.match_b  = 1'b0;
        next_s.sync_out = 1'b0;
        setup   = psel && !penable;
        access  = psel && penable && s.ready;
        clr_sel = tucc_clr_t'(s.control[CLR_LSB +: 2]);

        // a compare match is seen on the up-count tick that finds equality
        event_a = (cif.tick_up && s.count == s.gen_a) || capture_a;
        event_b = (cif.tick_up && s.count == s.gen_b) || capture_b;

        if (capture_a)
            next_s.gen_a = s.count;
        if (capture_b)
            next_s.gen_b = s.count;

        case (clr_sel)
            CLR_GEN_A: clear_now = event_a;
            CLR_GEN_B: clear_now = event_b;
            // sync clearing only while software has enabled it
            CLR_SYNC:  clear_now = s.mode[MODE_SYNC_BIT] && sync_clear_in;
            default:   clear_now = 1'b0;
        endcase

        if (clear_now)
            next_s.count = COUNT_RESET;
        else if (cif.tick_up)
            next_s.count = s.count + 16'h0001;
        else if (cif.tick_down)
            next_s.count = s.count - 16'h0001;

        next_s.match_a  = event_a;
        next_s.match_b  = event_b;
        // other channels follow only clears we make while in sync operation
        next_s.sync_out = clear_now && s.mode[MODE_SYNC_BIT];

        // setup phase: decode and stage read data so pready comes from a flop
        if (setup)
        begin
            next_s.ready  = 1'b1;
            next_s.slverr = !addr_known(paddr);
            if (addr_hit(paddr, IDX_CONTROL))
                next_s.rdata = {24'h000000, s.control & CONTROL_MASK};
            else if (addr_hit(paddr, IDX_MODE))
                next_s.rdata = {30'h00000000, s.mode};
            else if (addr_hit(paddr, IDX_COUNT))
                next_s.rdata = {16'h0000, s.count};
            else if (addr_hit(paddr, IDX_GEN_A))
                next_s.rdata = {16'h0000, s.gen_a};
            else if (addr_hit(paddr, IDX_GEN_B))
                next_s.rdata = {16'h0000, s.gen_b};
            else if (addr_hit(paddr, IDX_GEN_C))
                next_s.rdata = {16'h0000, s.gen_c};
            else if (addr_hit(paddr, IDX_GEN_D))
                next_s.rdata = {16'h0000, s.gen_d};
            else
                next_s.rdata = 32'h00000000;
        end

        // software write wins over counting and capture in the same cycle
        if (access && pwrite)
        begin
            if (addr_hit(paddr, IDX_CONTROL))
                next_s.control = pwdata[7:0] & CONTROL_MASK;
            else if (addr_hit(paddr, IDX_MODE))
                next_s.mode = pwdata[1:0] & MODE_MASK;
            else if (addr_hit(paddr, IDX_COUNT))
                next_s.count = pwdata[15:0];
            else if (addr_hit(paddr, IDX_GEN_A))
                next_s.gen_a = pwdata[15:0];
            else if (addr_hit(paddr, IDX_GEN_B))
                next_s.gen_b = pwdata[15:0];
            else if (addr_hit(paddr, IDX_GEN_C))
                next_s.gen_c = pwdata[15:0];
            else if (addr_hit(paddr, IDX_GEN_D))
                next_s.gen_d = pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s          <= '0;
            s.count    <= COUNT_RESET;
            s.gen_a    <= GEN_RESET;
            s.gen_b    <= GEN_RESET;
            s.gen_c    <= GEN_RESET;
            s.gen_d    <= GEN_RESET;
            s.control  <= CONTROL_RESET;
            s.mode     <= MODE_RESET;
        end
        else
            s <= next_s;
    end

    assign prdata         = s.rdata;
    assign pready         = s.ready;
    assign pslverr        = s.slverr;
    assign match_a        = s.match_a;
    assign match_b        = s.match_b;
    assign sync_clear_out = s.sync_out;

endmodule
`default_nettype wire
